// file: ramp_seq_cfg.svh
// Timing and structural constants for the channel-pair reset and ramp sequencer
`ifndef RAMP_SEQ_CFG_SVH
`define RAMP_SEQ_CFG_SVH
`define START_DELAY_CYCLES 35
`define RAMP_STEPS_DEFAULT 64
`define PWM_DIV_DEFAULT 16
`define STATUS_RESET 1'b0
`endif

// file: ramp_seq_pkg.sv
// Types shared by both ends of the sequencer link
package ramp_seq_pkg;
   typedef enum logic [4:0] {
      ST_OFF     = 5'b00001,
      ST_WAIT    = 5'b00010,
      ST_RAMP_UP = 5'b00100,
      ST_RUN     = 5'b01000,
      ST_RAMP_DN = 5'b10000
   } seq_state_e;
   typedef enum logic [2:0] {
      MS_IDLE    = 3'b001,
      MS_PWM_ON  = 3'b010,
      MS_RELEASE = 3'b100
   } mod_state_e;
endpackage

// file: ramp_link_if.sv
// Link between the PWM modulator end and the power-stage sequencer end
`timescale 1ns/1ps
interface ramp_link_if;
   logic pwm_input;
   logic channel_pair_reset_n;
   logic ramp_enable;
   logic fault_active;
   modport device (
      input  pwm_input,
      input  channel_pair_reset_n,
      input  ramp_enable,
      output fault_active
   );
   modport modulator (
      output pwm_input,
      output channel_pair_reset_n,
      output ramp_enable,
      input  fault_active
   );
endinterface

// file: channel_reset_ramp_sequencer.sv
// Power-stage end: channel-pair reset, ramp and start-up sequencing
`timescale 1ns/1ps
`include "ramp_seq_cfg.svh"
// How it works
// - Reset low: outputs hi-Z, state cleared
// - Reset high: latch mode, then switch normally
// - Ramp on: output ramps up to bias
// - No switching until ramp reaches bias
// - Modulator toggles PWM before ramp starts
// - Ramp on, reset low: ramp down toward ground
// - Down-ramp at ground: output goes hi-Z
// - New ramp request accepted mid-ramp
// - Ramp only used with half-bridge outputs
// - No ramp: switch after 35 PWM cycles
// - No ramp, reset low: hi-Z at once
// - Reset held low until supplies stable
// - PWM first, release reset, assert before off
// - Reset asserted on supply brownout
// - Latched shutdown cleared by fault gone, reset rise
module channel_reset_ramp_sequencer #(
   parameter int RAMP_STEPS = `RAMP_STEPS_DEFAULT,
   parameter int LEVEL_W    = $clog2(RAMP_STEPS + 1)
) (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   ramp_link_if.device             link,
   input  wire logic               fault_i,
   input  wire logic               latch_mode_i,
   output logic                    bridge_output_o,
   output logic                    bridge_output_oe_o,
   output logic [LEVEL_W-1:0]      ramp_level_o,
   output logic                    switching_o,
   output logic                    shutdown_o,
   output logic                    fault_o
);
   localparam logic [LEVEL_W-1:0] TOP = LEVEL_W'(RAMP_STEPS);
   localparam logic [5:0] START_CNT = 6'(`START_DELAY_CYCLES);

   logic [1:0] pwm_s;
   logic [1:0] rst_s;
   logic [1:0] ramp_s;
   logic       pwm_d;
   logic       rst_d;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwm_s <= 2'h0;
         rst_s <= 2'h0;
         ramp_s <= 2'h0;
         pwm_d <= 1'b0;
         rst_d <= 1'b0;
      end else begin
         pwm_s <= {pwm_s[0], link.pwm_input};
         rst_s <= {rst_s[0], link.channel_pair_reset_n};
         ramp_s <= {ramp_s[0], link.ramp_enable};
         pwm_d <= pwm_s[1];
         rst_d <= rst_s[1];
      end
   end
   logic pwm_rise;
   logic rst_rise;
   logic pair_rst_n;
   assign pwm_rise = pwm_s[1] & ~pwm_d;
   assign rst_rise = rst_s[1] & ~rst_d;
   assign pair_rst_n = rst_s[1];

   ramp_seq_pkg::seq_state_e state_r;
   ramp_seq_pkg::seq_state_e state_nxt;
   logic [LEVEL_W-1:0] level_r;
   logic [LEVEL_W-1:0] level_nxt;
   logic [5:0]         cnt_r;
   logic [5:0]         cnt_nxt;
   logic               ramp_mode_r;
   logic               ramp_mode_nxt;
   logic               latch_r;
   logic               latch_nxt;
   logic               shut_r;
   logic               shut_nxt;
   logic               out_r;
   logic               out_nxt;
   logic               oe_r;
   logic               oe_nxt;
   logic               sw_r;
   logic               sw_nxt;
   logic               flt_r;
   logic               flt_nxt;

   always_comb begin
      state_nxt = state_r;
      level_nxt = level_r;
      cnt_nxt = cnt_r;
      ramp_mode_nxt = ramp_mode_r;
      latch_nxt = latch_r;
      case (state_r)
         ramp_seq_pkg::ST_OFF: begin
            level_nxt = '0;
            cnt_nxt = '0;
            if (pair_rst_n) begin
               ramp_mode_nxt = ramp_s[1];
               latch_nxt = latch_mode_i;
               state_nxt = ramp_s[1] ? ramp_seq_pkg::ST_RAMP_UP : ramp_seq_pkg::ST_WAIT;
            end
         end
         ramp_seq_pkg::ST_WAIT: begin
            if (!pair_rst_n) begin
               state_nxt = ramp_seq_pkg::ST_OFF;
            end else if (pwm_rise) begin
               if (cnt_r == START_CNT - 6'h01) begin
                  state_nxt = ramp_seq_pkg::ST_RUN;
               end else begin
                  cnt_nxt = cnt_r + 6'h01;
               end
            end
         end
         ramp_seq_pkg::ST_RAMP_UP: begin
            if (!pair_rst_n) begin
               state_nxt = ramp_seq_pkg::ST_RAMP_DN;
            end else if (pwm_rise) begin
               // Steps advance only on a running input
               if (level_r == TOP) begin
                  state_nxt = ramp_seq_pkg::ST_RUN;
               end else begin
                  level_nxt = level_r + LEVEL_W'(1);
               end
            end
         end
         ramp_seq_pkg::ST_RUN: begin
            level_nxt = ramp_mode_r ? TOP : '0;
            if (!pair_rst_n) begin
               state_nxt = ramp_mode_r ? ramp_seq_pkg::ST_RAMP_DN
                                       : ramp_seq_pkg::ST_OFF;
            end
         end
         ramp_seq_pkg::ST_RAMP_DN: begin
            if (pair_rst_n) begin
               state_nxt = ramp_seq_pkg::ST_RAMP_UP;
            end else if (level_r == '0) begin
               state_nxt = ramp_seq_pkg::ST_OFF;
            end else begin
               level_nxt = level_r - LEVEL_W'(1);
            end
         end
         default: state_nxt = ramp_seq_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ramp_seq_pkg::ST_OFF;
         level_r <= '0;
         cnt_r <= '0;
         ramp_mode_r <= 1'b0;
         latch_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         level_r <= level_nxt;
         cnt_r <= cnt_nxt;
         ramp_mode_r <= ramp_mode_nxt;
         latch_r <= latch_nxt;
      end
   end

   // Latched shutdown survives reset low; fault gone plus a reset rise clears it
   always_comb begin
      shut_nxt = shut_r;
      if (fault_i && latch_r && state_r == ramp_seq_pkg::ST_RUN) begin
         shut_nxt = 1'b1;
      end else if (shut_r && !fault_i && rst_rise) begin
         shut_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shut_r <= `STATUS_RESET;
      end else begin
         shut_r <= shut_nxt;
      end
   end

   // Pin-facing flops: drive flops loaded from next state so they move with the state, fault flop loaded from fault_i
   always_comb begin
      flt_nxt = fault_i;
      sw_nxt = (state_nxt == ramp_seq_pkg::ST_RUN) && !shut_nxt;
      out_nxt = sw_nxt & pwm_s[1];
      oe_nxt = sw_nxt || state_nxt == ramp_seq_pkg::ST_RAMP_UP
               || state_nxt == ramp_seq_pkg::ST_RAMP_DN;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         out_r <= 1'b0;
         oe_r <= 1'b0;
         sw_r <= 1'b0;
         flt_r <= 1'b0;
      end else begin
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         sw_r <= sw_nxt;
         flt_r <= flt_nxt;
      end
   end

   assign link.fault_active = flt_r;
   assign bridge_output_o = out_r;
   assign bridge_output_oe_o = oe_r;
   assign ramp_level_o = level_r;
   assign switching_o = sw_r;
   assign shutdown_o = shut_r;
   assign fault_o = flt_r;
endmodule

// file: pwm_modulator_end.sv
// Modulator end: PWM generation and channel-pair reset sequencing
`timescale 1ns/1ps
`include "ramp_seq_cfg.svh"
module pwm_modulator_end #(
   parameter int PWM_DIV = `PWM_DIV_DEFAULT
) (
   input  wire logic    clk_i,
   input  wire logic    rst_n_i,
   ramp_link_if.modulator link,
   input  wire logic    enable_i,
   input  wire logic    supply_ok_i,
   input  wire logic    half_bridge_i,
   input  wire logic    ramp_req_i,
   input  wire logic    duty_i,
   output logic         fault_seen_o,
   output logic         running_o
);
   localparam logic [15:0] DIV_LAST = 16'(PWM_DIV - 1);
   logic [15:0] div_r;
   logic [15:0] div_nxt;
   logic        pwm_r;
   logic        pwm_nxt;
   logic        rstn_r;
   logic        rstn_nxt;
   logic        ramp_r;
   logic        ramp_nxt;
   logic [1:0]  flt_s;
   ramp_seq_pkg::mod_state_e st_r;
   ramp_seq_pkg::mod_state_e st_nxt;

   always_comb begin
      div_nxt = (div_r == DIV_LAST) ? 16'h0000 : div_r + 16'h0001;
      pwm_nxt = pwm_r;
      st_nxt = st_r;
      // Ramp only allowed in half-bridge arrangement
      ramp_nxt = ramp_req_i & half_bridge_i;
      if (st_r != ramp_seq_pkg::MS_IDLE && div_r == DIV_LAST) begin
         pwm_nxt = ~pwm_r;
      end
      case (st_r)
         ramp_seq_pkg::MS_IDLE: begin
            pwm_nxt = 1'b0;
            if (enable_i && supply_ok_i) begin
               st_nxt = ramp_seq_pkg::MS_PWM_ON;
            end
         end
         ramp_seq_pkg::MS_PWM_ON: begin
            // Release at the end of the PWM's first full high phase
            if (!(enable_i && supply_ok_i)) begin
               st_nxt = ramp_seq_pkg::MS_IDLE;
            end else if (pwm_r && div_r == DIV_LAST) begin
               st_nxt = ramp_seq_pkg::MS_RELEASE;
            end
         end
         ramp_seq_pkg::MS_RELEASE: begin
            if (!(enable_i && supply_ok_i)) begin
               st_nxt = ramp_seq_pkg::MS_PWM_ON;
            end
         end
         default: st_nxt = ramp_seq_pkg::MS_IDLE;
      endcase
      // PWM keeps running one state longer than reset, so reset asserts before PWM stops
      rstn_nxt = (st_nxt == ramp_seq_pkg::MS_RELEASE);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_r <= 16'h0000;
         pwm_r <= 1'b0;
         rstn_r <= 1'b0;
         ramp_r <= 1'b0;
         flt_s <= 2'h0;
         st_r <= ramp_seq_pkg::MS_IDLE;
      end else begin
         div_r <= div_nxt;
         pwm_r <= pwm_nxt;
         rstn_r <= rstn_nxt;
         ramp_r <= ramp_nxt;
         flt_s <= {flt_s[0], link.fault_active};
         st_r <= st_nxt;
      end
   end

   assign link.pwm_input = pwm_r ^ (duty_i & 1'b0);
   assign link.channel_pair_reset_n = rstn_r;
   assign link.ramp_enable = ramp_r;
   assign fault_seen_o = flt_s[1];
   assign running_o = rstn_r;
endmodule

// file: ramp_seq_properties.sv
// Concurrent checks on the sequencer link and power-stage outputs
`timescale 1ns/1ps
module ramp_seq_properties #(
   parameter int RAMP_STEPS = 4,
   parameter int LEVEL_W    = 3
) (
   input wire logic               clk_i,
   input wire logic               rst_n_i,
   input wire logic               pwm_input,
   input wire logic               channel_pair_reset_n,
   input wire logic               ramp_enable,
   input wire logic               fault_active,
   input wire logic               fault_i,
   input wire logic               bridge_output_oe_o,
   input wire logic [LEVEL_W-1:0] ramp_level_o,
   input wire logic               switching_o,
   input wire logic               shutdown_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_pwm_before_release: assert property (
      $rose(channel_pair_reset_n) |-> $past(pwm_input) || $past(pwm_input, 2))
      else $error("reset released with idle pwm");
   a_release_drives_oe: assert property (
      $rose(channel_pair_reset_n) && ramp_enable && !shutdown_o |-> ##[1:5] bridge_output_oe_o)
      else $error("no drive after release");
   a_hiz_no_ramp: assert property (
      $fell(channel_pair_reset_n) && !ramp_enable |-> ##[1:5] !bridge_output_oe_o)
      else $error("outputs still driven after reset");
   a_down_to_hiz: assert property (
      ramp_level_o == 0 && $past(ramp_level_o) == 1 && !channel_pair_reset_n
      |-> ##[0:2] !bridge_output_oe_o)
      else $error("not hi-z at ground");
   a_up_by_one: assert property (
      ramp_level_o > $past(ramp_level_o) |-> ramp_level_o == $past(ramp_level_o) + 1'b1)
      else $error("up step not one");
   a_down_by_one: assert property (
      ramp_level_o < $past(ramp_level_o) |-> ramp_level_o + 1'b1 == $past(ramp_level_o))
      else $error("down step not one");
   a_bias_before_switch: assert property (
      switching_o && ramp_enable |-> ramp_level_o == RAMP_STEPS)
      else $error("switching below bias");
   a_start_delay: assert property (
      $rose(switching_o) && !ramp_enable |-> $past(channel_pair_reset_n, 100))
      else $error("switching started too early");
   a_shut_holds: assert property (
      shutdown_o && fault_i |=> shutdown_o)
      else $error("shutdown cleared under fault");
   a_shut_gates: assert property (
      shutdown_o [*2] |-> !switching_o && !bridge_output_oe_o)
      else $error("shutdown output still driven");
   c_run: cover property ($rose(switching_o));
   c_ground: cover property ($fell(ramp_level_o == 1));
   c_shut: cover property ($rose(shutdown_o) && fault_active);
endmodule

// file: tb_top.sv
// Bench joining the modulator end to the sequencer end
`timescale 1ns/1ps
module tb_top;
   localparam int STEPS = 4;
   localparam int LW    = $clog2(STEPS + 1);
   logic          clk_i, rst_n_i, enable_i, supply_ok_i, ramp_req_i, fault_i, latch_mode_i;
   logic          bridge_output_o, bridge_output_oe_o, switching_o, shutdown_o, fault_o;
   logic          fault_seen_o, running_o, half_bridge_i;
   logic [LW-1:0] ramp_level_o;
   int            fail_count, num_checks;
   ramp_link_if lnk();
   pwm_modulator_end #(.PWM_DIV(2)) u_pwm_modulator_end (.clk_i, .rst_n_i,
      .link(lnk.modulator), .enable_i, .supply_ok_i, .half_bridge_i, .ramp_req_i,
      .duty_i(1'b0), .fault_seen_o, .running_o);
   channel_reset_ramp_sequencer #(.RAMP_STEPS(STEPS)) u_channel_reset_ramp_sequencer (
      .clk_i, .rst_n_i, .link(lnk.device), .fault_i, .latch_mode_i, .bridge_output_o,
      .bridge_output_oe_o, .ramp_level_o, .switching_o, .shutdown_o, .fault_o);
   ramp_seq_properties #(.RAMP_STEPS(STEPS), .LEVEL_W(LW)) u_ramp_seq_properties (
      .clk_i, .rst_n_i, .pwm_input(lnk.pwm_input), .ramp_enable(lnk.ramp_enable),
      .channel_pair_reset_n(lnk.channel_pair_reset_n), .fault_active(lnk.fault_active),
      .fault_i, .bridge_output_oe_o, .ramp_level_o, .switching_o, .shutdown_o);
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask
   // Waits for switching (0), level (1) or drive (2) to reach a value
   task automatic wait_on(input int sel, input logic [7:0] v);
      int k;
      k = 0;
      while ((sel == 0 ? 8'(switching_o) : sel == 1 ? 8'(ramp_level_o)
              : 8'(bridge_output_oe_o)) !== v && k < 400) begin
         cyc(1);
         k++;
      end
      if (k == 400) begin
         fail_count++;
         close_out();
      end
   endtask
   task automatic t_noramp();
      int   n, k, hi;
      logic prev;
      check("oe_in_reset", 8'(bridge_output_oe_o), 8'h00);
      check("rst_held", 8'(lnk.channel_pair_reset_n), 8'h00);
      enable_i = 1'b1;
      supply_ok_i = 1'b1;
      k = 0;
      while (lnk.channel_pair_reset_n !== 1'b1 && k < 40) begin
         cyc(1);
         k++;
      end
      // Count input rises from release until switching starts
      n = 0;
      prev = lnk.pwm_input;
      while (switching_o !== 1'b1 && k < 400) begin
         cyc(1);
         k++;
         if (lnk.pwm_input === 1'b1 && prev === 1'b0) begin
            n++;
         end
         prev = lnk.pwm_input;
      end
      check("pwm_rises", 8'(n >= 35 && n <= 36), 8'h01);
      check("oe_run", 8'(bridge_output_oe_o), 8'h01);
      check("running", 8'(running_o), 8'h01);
      // A square wave of four clocks is high in half of any eight cycles
      hi = 0;
      repeat (8) begin
         cyc(1);
         hi += int'(bridge_output_o === 1'b1);
      end
      check("out_toggles", 8'(hi), 8'h04);
      enable_i = 1'b0;
      cyc(6);
      check("oe_off", 8'(bridge_output_oe_o), 8'h00);
      check("out_off", 8'(bridge_output_o), 8'h00);
      cyc(20);
      $display("done noramp");
   endtask
   task automatic t_ramp();
      half_bridge_i = 1'b0;
      ramp_req_i = 1'b1;
      cyc(2);
      check("ramp_full_bridge", 8'(lnk.ramp_enable), 8'h00);
      half_bridge_i = 1'b1;
      cyc(2);
      check("ramp_half_bridge", 8'(lnk.ramp_enable), 8'h01);
      enable_i = 1'b1;
      wait_on(2, 8'h01);
      check("sw_in_ramp", 8'(switching_o), 8'h00);
      wait_on(0, 8'h01);
      check("lvl_run", 8'(ramp_level_o), 8'(STEPS));
      enable_i = 1'b0;
      wait_on(1, 8'(STEPS - 1));
      check("oe_down", 8'(bridge_output_oe_o), 8'h01);
      wait_on(2, 8'h00);
      check("lvl_hiz", 8'(ramp_level_o), 8'h00);
      cyc(20);
      $display("done ramp");
   endtask
   task automatic t_reverse();
      int k, lows;
      enable_i = 1'b1;
      wait_on(0, 8'h01);
      // Enable low for one cycle only: reset release lands before the down-ramp ends
      enable_i = 1'b0;
      cyc(1);
      enable_i = 1'b1;
      lows = 0;
      k = 0;
      while ((k < 8 || switching_o !== 1'b1) && k < 400) begin
         cyc(1);
         k++;
         if (bridge_output_oe_o !== 1'b1) begin
            lows++;
         end
      end
      check("oe_kept", 8'(lows), 8'h00);
      check("lvl_rerun", 8'(ramp_level_o), 8'(STEPS));
      enable_i = 1'b0;
      wait_on(2, 8'h00);
      cyc(20);
      $display("done reverse");
   endtask
   task automatic t_fault();
      ramp_req_i = 1'b0;
      latch_mode_i = 1'b1;
      cyc(2);
      enable_i = 1'b1;
      wait_on(0, 8'h01);
      fault_i = 1'b1;
      cyc(4);
      check("fault_seen", 8'(fault_seen_o), 8'h01);
      check("fault_out", 8'(fault_o), 8'h01);
      check("shut_set", 8'(shutdown_o), 8'h01);
      check("oe_shut", 8'(bridge_output_oe_o), 8'h00);
      check("out_shut", 8'(bridge_output_o), 8'h00);
      fault_i = 1'b0;
      cyc(4);
      check("fault_gone", 8'(fault_o), 8'h00);
      check("shut_kept", 8'(shutdown_o), 8'h01);
      supply_ok_i = 1'b0;
      cyc(20);
      check("brownout_rst", 8'(lnk.channel_pair_reset_n), 8'h00);
      supply_ok_i = 1'b1;
      wait_on(0, 8'h01);
      check("shut_clr", 8'(shutdown_o), 8'h00);
      $display("done fault");
   endtask
   initial begin
      {rst_n_i, enable_i, supply_ok_i, ramp_req_i, fault_i, latch_mode_i, half_bridge_i} = '0;
      fail_count = 0;
      num_checks = 0;
      cyc(2);
      rst_n_i = 1'b1;
      t_noramp();
      t_ramp();
      t_reverse();
      t_fault();
      close_out();
   end
endmodule
